/* logic/tab_bridge.sv */
// Trace stream bridge: slave port half and master port half joined by crossing signals.
// Assumes synchronous inputs on clock_i; beat accept and beat load happen only on the clock enable of their half.
//
// Operation
// - Byte count is valid bytes minus one, LSB lane aligned.
// - Master port repeats accepted byte count unchanged.
// - Data width fixed build value, both ports alike.
// - Byte-count width fixed build value, both ports.
// - Seven-bit source ID travels with its data.
// - Master flush request raised on slave port.
// - Flush completion reported back per forwarded request.
// - Clock-active high while master clock still needed.
// - Powerdown request, acknowledge, clock-active on master clock.
// - Halves joined only through defined crossing set.
// - Forward data, safe state, reverse pointer, flush and sync handshakes.
// - Fields ignored while valid is low.
`timescale 1ns/1ps
module tab_bridge
  import tab_pkg::*;
(
  input wire logic clock_i, // Clock, 200 MHz.
  input wire logic rst_b_i, // Whole bridge reset, active low.
  input wire logic slv_rst_b_i, // Slave half reset, active low.
  input wire logic mst_rst_b_i, // Master half reset, active low.
  input wire logic slv_clken_i, // Slave half clock enable.
  input wire logic mst_clken_i, // Master half clock enable.
  input tab_pkg::tab_beat_type slv_beat_i, // Incoming beat.
  input wire logic slv_flush_done_i, // Upstream flush complete.
  input wire logic mst_ready_i, // Downstream ready.
  input wire logic mst_flush_req_i, // Downstream flush request.
  input wire logic sync_req_i, // Sync request, master side.
  input wire logic pwrdn_req_b_i, // Powerdown request, active low.
  output logic slv_ready_o, // Ready to upstream.
  output logic slv_flush_req_o, // Flush request upstream.
  output logic sync_req_o, // Sync request upstream.
  output tab_pkg::tab_beat_type mst_beat_o, // Outgoing beat.
  output logic mst_flush_done_o, // Flush complete downstream.
  output logic clk_active_o, // Master clock needed.
  output logic pwrdn_ack_b_o // Powerdown acknowledge, active low.
);
  logic s_rst;
  logic m_rst;
  assign s_rst = !rst_b_i || !slv_rst_b_i;
  assign m_rst = !rst_b_i || !mst_rst_b_i;

  // Crossing wires between the halves.
  tab_fwd_type fwd;
  tab_rev_type rev;

  // Storage written by the slave half and read by the master half.
  logic [ID_MSB+BYTES_MSB+DATA_MSB+2:0] mem [2**ADDR_W];

  // Synchroniser flops.
  logic [PTR_W-1:0] rd_g1, rd_g2, wr_g1, wr_g2;
  logic zero1, zero2, safe1, safe2, fl1, fl2, fd1, fd2, sr1, sr2, sa1, sa2;

  // Slave half state.
  logic [PTR_W-1:0] wr_reg, wr_next;
  logic s_ready_reg, s_ready_next, s_flush_reg, s_flush_next;
  logic s_done_reg, s_done_next, s_ack_reg, s_ack_next;
  logic s_pulse_reg, s_pulse_next;
  logic accept;
  logic [PTR_W-1:0] rd_s;

  // Master half state.
  logic [PTR_W-1:0] rd_reg, rd_next, wr_m;
  tab_beat_type out_reg, out_next;
  logic m_done_reg, m_done_next, m_req_reg, m_req_next, m_pend_reg, m_pend_next;
  logic act_reg, act_next, ack_reg, ack_next;
  logic avail, take, load, busy_m;

  // Two-flop crossings in both directions.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      {rd_g1, rd_g2, wr_g1, wr_g2} <= '0;
      {zero1, zero2, safe1, safe2} <= 4'hf;
      {fl1, fl2, fd1, fd2, sr1, sr2, sa1, sa2} <= 8'h00;
    end else begin
      rd_g1 <= rev.rd_gray;
      rd_g2 <= rd_g1;
      zero1 <= rev.zero;
      zero2 <= zero1;
      wr_g1 <= fwd.wr_gray;
      wr_g2 <= wr_g1;
      safe1 <= fwd.safe;
      safe2 <= safe1;
      fl1 <= mst_flush_req_i;
      fl2 <= fl1;
      fd1 <= s_done_reg;
      fd2 <= fd1;
      sr1 <= m_req_reg;
      sr2 <= sr1;
      sa1 <= s_ack_reg;
      sa2 <= sa1;
    end
  end

  // Crossing signal set driven by each half.
  always_comb begin
    fwd.safe = s_rst;
    fwd.wr_gray = tab_to_gray(wr_reg);
    rev.zero = m_rst;
    rev.rd_gray = tab_to_gray(rd_reg);
  end

  // Slave half next state: accept, flush forwarding, sync handshake.
  always_comb begin
    rd_s = tab_to_bin(rd_g2);
    accept = slv_clken_i && slv_beat_i.valid && s_ready_reg;
    wr_next = zero2 ? PTR_ZERO : wr_reg + (accept ? PTR_ONE : PTR_ZERO);
    s_ready_next = !zero2 && ((wr_next - rd_s) < FIFO_DEPTH);
    s_done_next = s_done_reg;
    s_flush_next = s_flush_reg;
    // A completion that meets the clear in one cycle still sets the flag.
    if (slv_clken_i && s_flush_reg && slv_flush_done_i) begin
      s_done_next = 1'b1;
    end else if (!fl2) begin
      s_done_next = 1'b0;
    end
    if (slv_clken_i) begin
      s_flush_next = fl2 && !s_done_next;
    end
    s_ack_next = s_ack_reg;
    s_pulse_next = s_pulse_reg;
    if (slv_clken_i) begin
      s_pulse_next = 1'b0;
    end
    if (!sr2) begin
      s_ack_next = 1'b0;
    end else if (!s_ack_reg && slv_clken_i) begin
      s_ack_next = 1'b1;
      s_pulse_next = 1'b1;
    end
  end

  // Slave half registers and storage writes.
  always_ff @(posedge clock_i) begin
    if (s_rst) begin
      wr_reg <= PTR_ZERO;
      s_ready_reg <= 1'b0;
      s_flush_reg <= 1'b0;
      s_done_reg <= 1'b0;
      s_ack_reg <= 1'b0;
      s_pulse_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      s_ready_reg <= s_ready_next;
      s_flush_reg <= s_flush_next;
      s_done_reg <= s_done_next;
      s_ack_reg <= s_ack_next;
      s_pulse_reg <= s_pulse_next;
    end
  end

  // Beat payload kept whole: ID, count and data stored together.
  always_ff @(posedge clock_i) begin
    if (accept) begin
      mem[wr_reg[ADDR_W-1:0]] <= {slv_beat_i.id, slv_beat_i.bytes, slv_beat_i.data};
    end
  end

  // Master half next state: output beat, flush answer, sync request, low power.
  always_comb begin
    wr_m = tab_to_bin(wr_g2);
    avail = wr_m != rd_reg;
    take = mst_clken_i && out_reg.valid && mst_ready_i;
    load = mst_clken_i && (!out_reg.valid || mst_ready_i) && avail;
    out_next = out_reg;
    if (mst_clken_i && (!out_reg.valid || mst_ready_i)) begin
      out_next.valid = avail;
    end
    if (load) begin
      {out_next.id, out_next.bytes, out_next.data} = mem[rd_reg[ADDR_W-1:0]];
    end
    rd_next = safe2 ? PTR_ZERO : rd_reg + (load ? PTR_ONE : PTR_ZERO);
    m_done_next = 1'b0;
    if (mst_clken_i && mst_flush_req_i && fd2 && !avail && !out_reg.valid && !m_done_reg) begin
      m_done_next = 1'b1;
    end
    m_req_next = m_req_reg;
    m_pend_next = m_pend_reg || (mst_clken_i && sync_req_i);
    if (m_req_reg && sa2) begin
      m_req_next = 1'b0;
    end else if (!m_req_reg && !sa2 && m_pend_next) begin
      m_req_next = 1'b1;
      m_pend_next = 1'b0;
    end
    busy_m = avail || out_reg.valid || mst_flush_req_i || m_req_reg || m_pend_reg || sa2;
    act_next = LOW_POWER_OPTION ? busy_m : 1'b1;
    ack_next = ack_reg;
    if (LOW_POWER_OPTION && (pwrdn_req_b_i || !busy_m)) begin
      ack_next = pwrdn_req_b_i;
    end
  end

  // Master half registers.
  always_ff @(posedge clock_i) begin
    if (m_rst) begin
      rd_reg <= PTR_ZERO;
      out_reg <= '0;
      m_done_reg <= 1'b0;
      m_req_reg <= 1'b0;
      m_pend_reg <= 1'b0;
      act_reg <= 1'b1;
      ack_reg <= 1'b1;
    end else begin
      rd_reg <= rd_next;
      out_reg <= out_next;
      m_done_reg <= m_done_next;
      m_req_reg <= m_req_next;
      m_pend_reg <= m_pend_next;
      act_reg <= act_next;
      ack_reg <= ack_next;
    end
  end

  assign slv_ready_o = s_ready_reg;
  assign slv_flush_req_o = s_flush_reg;
  assign sync_req_o = s_pulse_reg;
  assign mst_beat_o = out_reg;
  assign mst_flush_done_o = m_done_reg;
  assign clk_active_o = act_reg;
  assign pwrdn_ack_b_o = ack_reg;

  // Helper counts of beats in and out, for the loss and duplication check.
  logic [7:0] in_cnt, out_cnt;
  always_ff @(posedge clock_i) begin
    if (s_rst || m_rst) begin
      in_cnt <= 8'h00;
      out_cnt <= 8'h00;
    end else begin
      in_cnt <= in_cnt + (accept ? CNT_ONE : 8'h00);
      out_cnt <= out_cnt + (take ? CNT_ONE : 8'h00);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (s_rst || m_rst);

  sequence held_beat;
    mst_beat_o.valid && !(mst_clken_i && mst_ready_i);
  endsequence

  a_beat_hold: assert property (held_beat |=> mst_beat_o.valid && $stable(mst_beat_o))
    else $error("Master beat changed before transfer.");
  a_no_overrun: assert property ((in_cnt - out_cnt) <= CNT_SLACK)
    else $error("Beats in flight exceed storage.");
  a_no_underrun: assert property (take |-> in_cnt != out_cnt)
    else $error("Beat delivered that was never accepted.");
  a_flush_fwd: assert property (fl2 && !s_done_reg && slv_clken_i ##1 fl2 && !s_done_reg |-> slv_flush_req_o)
    else $error("Flush request not forwarded.");
  a_flush_done: assert property (mst_flush_done_o |-> $past(mst_flush_req_i) && $past(fd2))
    else $error("Flush complete without completed request.");
  a_sync_pulse: assert property (sync_req_o && slv_clken_i |=> !sync_req_o)
    else $error("Sync request longer than one enabled cycle.");
  a_clk_needed: assert property (mst_beat_o.valid && $past(mst_beat_o.valid) |-> clk_active_o)
    else $error("Clock-active low with beat pending.");
  a_ack_follow: assert property ($changed(pwrdn_ack_b_o) |-> pwrdn_ack_b_o == $past(pwrdn_req_b_i))
    else $error("Powerdown acknowledge moved against request.");
  a_ready_room: assert property (slv_ready_o |-> (wr_reg - rd_s) < FIFO_DEPTH)
    else $error("Ready with storage full.");
endmodule

/* logic/tab_pkg.sv */
// Package for the trace stream bridge: widths, FIFO sizing, beat and crossing types.
// Assumes one clock drives both halves, each half gated by its own clock enable.
package tab_pkg;
  // Data MSB index, one of 7, 15, 31 or 63; same on both ports.
  localparam int DATA_MSB = 31;
  // Byte-count MSB index, 0 to 3; count is bytes minus one, LSB lane aligned.
  localparam int BYTES_MSB = 1;
  localparam int ID_MSB = 6;
  localparam int ADDR_W = 2;
  localparam int PTR_W = ADDR_W + 1;
  localparam logic [PTR_W-1:0] FIFO_DEPTH = 3'h4;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
  localparam logic [PTR_W-1:0] PTR_ZERO = 3'h0;
  // Low-power clock handshake present when set.
  localparam logic LOW_POWER_OPTION = 1'h1;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_SLACK = 8'h05;

  // One trace beat with its qualifier.
  typedef struct packed {
    logic valid;
    logic [ID_MSB:0] id;
    logic [BYTES_MSB:0] bytes;
    logic [DATA_MSB:0] data;
  } tab_beat_type;

  // Slave half to master half.
  typedef struct packed {
    logic safe;
    logic [PTR_W-1:0] wr_gray;
  } tab_fwd_type;

  // Master half to slave half.
  typedef struct packed {
    logic zero;
    logic [PTR_W-1:0] rd_gray;
  } tab_rev_type;

  // Binary to gray.
  function automatic logic [PTR_W-1:0] tab_to_gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray to binary.
  function automatic logic [PTR_W-1:0] tab_to_bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

/* dv/tab_far_model.sv */
// Far-side model: downstream trace sink ready and upstream flush responder.
// Assumes one clock shared with the bridge; outputs move 1 ns after the edge.
`timescale 1ns/1ps
module tab_far_model (
  input wire logic clock_i, // Clock.
  input wire logic rst_b_i, // Reset, active low.
  input wire logic slow_i, // Stall most cycles when high.
  input wire logic flush_req_i, // Flush request from the bridge.
  output logic ready_o, // Sink ready.
  output logic flush_done_o // Upstream flush complete.
);
  int seed = 24167;

  initial begin
    ready_o = 1'h0;
    flush_done_o = 1'h0;
  end

  // Ready is drawn each cycle; flush completes some cycles after the request.
  always @(posedge clock_i) begin
    ready_o <= #1 rst_b_i && (slow_i ? ($random(seed) & 3) == 0 : ($random(seed) & 3) != 0);
    flush_done_o <= #1 rst_b_i && flush_req_i && ($random(seed) & 1);
  end
endmodule

/* dv/test_tab_bridge.sv */
// Self-checking bench for the trace stream bridge.
// Assumes the far-side model supplies sink ready and upstream flush completion.
`timescale 1ns/1ps
module test_tab_bridge;
  import tab_pkg::*;
  logic clock_i = 0, rst_b_i = 0, slv_clken_i = 1, mst_clken_i = 1, mst_flush_req_i = 0, sync_req_i = 0;
  logic pwrdn_req_b_i = 1, slow = 0, gate = 0, mst_ready_i, slv_flush_done_i;
  logic slv_ready_o, slv_flush_req_o, sync_req_o, mst_flush_done_o, clk_active_o, pwrdn_ack_b_o;
  tab_beat_type slv_beat_i = '0, mst_beat_o, exp_beat;
  tab_beat_type exp_q[$];
  int seed = 24167, miscompares = 0, n_compared = 0, i;

  tab_bridge DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .slv_rst_b_i(rst_b_i), .mst_rst_b_i(rst_b_i),
    .slv_clken_i(slv_clken_i), .mst_clken_i(mst_clken_i), .slv_beat_i(slv_beat_i),
    .slv_flush_done_i(slv_flush_done_i), .mst_ready_i(mst_ready_i), .mst_flush_req_i(mst_flush_req_i),
    .sync_req_i(sync_req_i), .pwrdn_req_b_i(pwrdn_req_b_i), .slv_ready_o(slv_ready_o),
    .slv_flush_req_o(slv_flush_req_o), .sync_req_o(sync_req_o), .mst_beat_o(mst_beat_o),
    .mst_flush_done_o(mst_flush_done_o), .clk_active_o(clk_active_o), .pwrdn_ack_b_o(pwrdn_ack_b_o));

  tab_far_model far (.clock_i(clock_i), .rst_b_i(rst_b_i), .slow_i(slow), .flush_req_i(slv_flush_req_o),
    .ready_o(mst_ready_i), .flush_done_o(slv_flush_done_i));

  // The clock toggles every half period of 2.5 ns.
  initial forever #2.5 clock_i = ~clock_i;

  // Clock enables are gated at random while gate is set.
  always @(posedge clock_i) begin
    slv_clken_i <= #1 !gate | ($random(seed) & 1);
    mst_clken_i <= #1 !gate | ($random(seed) & 1);
  end

  // Every beat taken on the master port must be the oldest beat sent.
  always @(posedge clock_i) begin
    if (rst_b_i && mst_clken_i && mst_ready_i && mst_beat_o.valid === 1'b1) begin
      exp_beat = exp_q.size() ? exp_q.pop_front() : '0;
      chk("beat", exp_beat, mst_beat_o);
      chk("clk_active_busy", 1, clk_active_o);
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Holds a valid beat until taken, then records it as expected.
  task automatic send(input logic [6:0] id, input logic [1:0] nb, input logic [31:0] d);
    int k;
    slv_beat_i = '{1'b1, id, nb, d};
    for (k = 0; k < 200; k++) begin
      @(posedge clock_i);
      if (slv_clken_i && slv_ready_o) break;
    end
    if (k == 200) begin
      chk("send_taken", 1, 0);
      results();
    end
    exp_q.push_back(slv_beat_i);
    #1;
  endtask

  // Drops valid and scrambles the other fields, which must then be ignored.
  task automatic idle();
    slv_beat_i = '{1'b0, ~slv_beat_i.id, slv_beat_i.bytes + 2'h1, ~slv_beat_i.data};
  endtask

  task automatic drain(input string nm);
    int k;
    for (k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge clock_i);
    #1;
    chk(nm, 0, exp_q.size());
    if (k == 300) results();
  endtask

  // Waits a bounded time for an output to reach a level: 0 flush up, 1 done, 2 sync, 3 ack.
  task automatic wt(input int s, input logic v, input string nm);
    logic g;
    int k;
    for (k = 0; k < 100; k++) begin
      @(posedge clock_i);
      #1;
      g = s == 0 ? slv_flush_req_o : s == 1 ? mst_flush_done_o : s == 2 ? sync_req_o : pwrdn_ack_b_o;
      if (g === v) break;
    end
    chk(nm, v, g);
    if (k == 100) results();
  endtask

  // Main sequence: stream, flush, sync, powerdown, mid-run reset.
  initial begin
    repeat (10) @(posedge clock_i);
    #1;
    rst_b_i = 1;
    repeat (6) @(posedge clock_i);
    #1;
    gate = 1;
    for (i = 0; i < 48; i++) begin
      slow = i >= 24;
      send(i == 0 ? 7'h7f : 7'($random(seed)), 2'(i), 32'($random(seed)));
      if (i % 8 == 7) begin
        idle();
        repeat (3) @(posedge clock_i);
        #1;
      end
    end
    idle();
    drain("stream_drained");
    $display("test stream done");
    send(7'h00, 2'h3, 32'hffffffff);
    send(7'h15, 2'h0, 32'h000000a5);
    idle();
    mst_flush_req_i = 1;
    wt(0, 1, "flush_req_up");
    wt(1, 1, "flush_done");
    chk("flush_empty", 0, exp_q.size());
    mst_flush_req_i = 0;
    repeat (8) @(posedge clock_i);
    $display("test flush done");
    #1;
    gate = 0;
    // Let the enables settle high so the one-cycle sync pulse meets an enabled edge.
    @(posedge clock_i);
    #1;
    sync_req_i = 1;
    @(posedge clock_i);
    #1;
    sync_req_i = 0;
    wt(2, 1, "sync_up");
    $display("test sync done");
    repeat (10) @(posedge clock_i);
    #1;
    pwrdn_req_b_i = 0;
    wt(3, 0, "pwrdn_ack_low");
    chk("clk_active_idle", 0, clk_active_o);
    pwrdn_req_b_i = 1;
    wt(3, 1, "pwrdn_ack_high");
    $display("test powerdown done");
    rst_b_i = 0;
    repeat (4) @(posedge clock_i);
    #1;
    rst_b_i = 1;
    send(7'h2a, 2'h2, 32'h00c0ffee);
    idle();
    drain("after_reset");
    $display("test reset done");
    results();
  end
endmodule
